// file: inc/edhso_pkg.sv
// Constants, register map and field layout of the EDH status and output select block
// Overview of operation
// [R1] Select low: pins show detected standard
// [R2] Select high: pins show field number bits
// [R3] Flag select code picks flag pair shown
// [R4] Status and internal flags OR all regions
// [R5] Missing upstream EDH packet raises unknown status
// [R6] Standard auto detected, host may override it
// [R7] Host reads flags, written flags replace computed
// [R8] Device answers host accesses only as slave
// [R9] Readable 21 bit errored fields counter
// [R10] Pass-through mode inserts no EDH packet
// [R11] Reserved packet words readable and writable
// [R12] Receive checks flags, transmit clears them
// [R13] Flag outputs active high, held one field
// [R14] Video out four clocks after video in
// [R15] Output selects registered within one clock
package edhso_pkg;
    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int VID_W = 10;
    localparam int PIPE_DEPTH = 4;
    localparam int CNT_W = 21;
    localparam int FLAGS_W = 15;
    localparam int STD_W = 3;
    localparam int FIELD_W = 3;
    localparam int RSV_N = 7;
    localparam int RSV_IDX_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Flag layout: five bits per region, three regions
    // ------------------------------------------------------------
    localparam int FB_EDH = 0;
    localparam int FB_ALREADY = 1;
    localparam int FB_FAULT_HERE = 2;
    localparam int FB_FAULT_UP = 3;
    localparam int FB_UNKNOWN = 4;
    localparam int RG_AP = 0;
    localparam int RG_FF = 5;
    localparam int RG_ANC = 10;
    localparam logic [FLAGS_W-1:0] UNKNOWN_ALL_MASK = 15'h4210;
    localparam logic [FLAGS_W-1:0] ERR_MASK = 15'h0C63;

    // ------------------------------------------------------------
    // Standard word bits and override layout
    // ------------------------------------------------------------
    localparam int SB_LUM = 0;
    localparam int SB_SAMP = 1;
    localparam int SB_PAL = 2;
    localparam int STD_OVR_EN = 3;
    localparam int STD_OVR_W = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_FLAG_OVR = 8'h04;
    localparam logic [ADDR_W-1:0] A_STD_OVR = 8'h08;
    localparam logic [ADDR_W-1:0] A_FLAGS = 8'h0C;
    localparam logic [ADDR_W-1:0] A_ERR_CNT = 8'h10;
    localparam logic [ADDR_W-1:0] A_STD_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] A_INT_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] A_INT_CLR = 8'h1C;
    localparam logic [ADDR_W-1:0] A_INT_EN = 8'h20;
    localparam logic [ADDR_W-1:0] A_RSV_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] A_RSV_MASK = 8'hE3;

    // ------------------------------------------------------------
    // Control, interrupt bits and reset values
    // ------------------------------------------------------------
    localparam int CB_PASS = 0;
    localparam int CB_FOVR = 1;
    localparam int IB_ERRF = 0;
    localparam int IB_UNKNOWN = 1;
    localparam int IB_STD = 2;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_MAX = 21'h1FFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;
endpackage : edhso_pkg

// file: logic/edhso_delay.sv
// Fixed depth video delay line
`timescale 1ns/100ps
`default_nettype none
module edhso_delay
    import edhso_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Video
    input wire logic [VID_W-1:0] din,
    output logic [VID_W-1:0] dout
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PIPE_DEPTH-1:0][VID_W-1:0] stage;
    } edhso_pipe_t;

    edhso_pipe_t s;
    edhso_pipe_t next_s;

    // Shift one stage per clock; no stall, so latency never varies
    always_comb begin
        next_s = s;
        next_s.stage[0] = din;
        for (int i = 1; i < PIPE_DEPTH; i++) begin
            next_s.stage[i] = s.stage[i-1];
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.stage[PIPE_DEPTH-1]; // Last stage is a flip-flop
endmodule : edhso_delay
`default_nettype wire

// file: logic/edhso_top.sv
// EDH status face: indication pins, flag pins, registers and video delay
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module edhso_top
    import edhso_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Mode and select pins
    input wire logic mode_receive,
    input wire logic field_std_select,
    input wire logic flag_select_lsb,
    input wire logic flag_select_msb,
    // Video stream
    input wire logic [VID_W-1:0] din,
    output logic [VID_W-1:0] dout,
    // Results from the check and timing logic
    input wire logic field_start,
    input wire logic [FIELD_W-1:0] field_number,
    input wire logic [STD_W-1:0] std_detected,
    input wire logic [FLAGS_W-1:0] computed_flags,
    input wire logic edh_packet_seen,
    // Indication and flag pins
    output logic indication_bit2,
    output logic indication_bit1,
    output logic indication_bit0,
    output logic flag_out_high,
    output logic flag_out_low,
    // Packet insertion side
    output logic insert_enable,
    output logic [FLAGS_W-1:0] insert_flags,
    output logic [RSV_N*VID_W-1:0] reserved_words,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic pass;
        logic fovr;
        logic [FLAGS_W-1:0] flag_ovr;
        logic [STD_OVR_W-1:0] std_ovr;
        logic [RSV_N-1:0][VID_W-1:0] rsv;
        logic [FLAGS_W-1:0] held;
        logic pkt_seen;
        logic [CNT_W-1:0] err_cnt;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [STD_W-1:0] std_prev;
        logic [DATA_W-1:0] rdata;
        logic [2:0] ind;
        logic fl_hi;
        logic fl_lo;
        logic irq;
        logic [FLAGS_W-1:0] ins_flags;
        logic ins_en;
    } edhso_state_t;

    edhso_state_t s;
    edhso_state_t next_s;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // OR of one flag kind over active picture, full field and ancillary
    function automatic logic region_or(input logic [FLAGS_W-1:0] f, input int kind);
        region_or = f[RG_AP+kind] | f[RG_FF+kind] | f[RG_ANC+kind];
    endfunction : region_or

    // True when the address falls on one of the reserved word slots
    function automatic logic rsv_hit(input logic [ADDR_W-1:0] a);
        logic [RSV_IDX_W-1:0] idx;
        idx = a[RSV_IDX_W+1:2];
        rsv_hit = ((a & A_RSV_MASK) == A_RSV_BASE) && (int'(idx) < RSV_N);
    endfunction : rsv_hit

    // Reserved word index from the address
    function automatic logic [RSV_IDX_W-1:0] rsv_idx(input logic [ADDR_W-1:0] a);
        rsv_idx = a[RSV_IDX_W+1:2];
    endfunction : rsv_idx

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [STD_W-1:0] eff_std;
        logic [FLAGS_W-1:0] cap;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic errored;
        logic [DATA_W-1:0] rd;
        eff_std = '0;
        cap = '0;
        ev = '0;
        clr = '0;
        errored = 1'b0;
        rd = '0;
        next_s = s;

        // Written standard wins over the detected one while enabled
        if (s.std_ovr[STD_OVR_EN]) begin // R6
            eff_std = s.std_ovr[STD_W-1:0]; // R6
        end else begin
            eff_std = std_detected; // R6
        end

        // Field boundary: capture the finished field's flags and hold them
        if (field_start) begin
            cap = computed_flags;
            // No packet in the whole field means upstream has no EDH
            if (mode_receive && !(s.pkt_seen || edh_packet_seen)) begin
                cap = cap | UNKNOWN_ALL_MASK; // R5
            end
            // Transmit mode starts every field with clean flags
            if (!mode_receive) begin
                cap = '0; // R12
            end
            next_s.held = cap; // R13
            next_s.pkt_seen = 1'b0;
            errored = |(cap & ERR_MASK);
            ev[IB_ERRF] = errored;
            ev[IB_UNKNOWN] = region_or(cap, FB_UNKNOWN) & ~region_or(s.held, FB_UNKNOWN);
        end else if (edh_packet_seen) begin
            next_s.pkt_seen = 1'b1;
        end

        // Standard change event, also fires when an override changes the effective standard
        ev[IB_STD] = (eff_std != s.std_prev);
        next_s.std_prev = eff_std;

        // Register writes
        if (wr_stb) begin
            case (addr)
                A_CTRL: begin
                    next_s.pass = wdata[CB_PASS]; // R10
                    next_s.fovr = wdata[CB_FOVR]; // R7
                end
                A_FLAG_OVR: begin
                    next_s.flag_ovr = wdata[FLAGS_W-1:0]; // R7
                end
                A_STD_OVR: begin
                    next_s.std_ovr = wdata[STD_OVR_W-1:0]; // R6
                end
                A_ERR_CNT: begin
                    next_s.err_cnt = '0;
                end
                A_INT_CLR: begin
                    clr = wdata[IRQ_W-1:0];
                end
                A_INT_EN: begin
                    next_s.irq_en = wdata[IRQ_W-1:0];
                end
                default: begin
                    if (rsv_hit(addr)) begin
                        next_s.rsv[rsv_idx(addr)] = wdata[VID_W-1:0]; // R11
                    end
                end
            endcase
        end

        // Errored fields count; a count in the clearing cycle is kept
        if (errored && (next_s.err_cnt != CNT_MAX)) begin
            next_s.err_cnt = next_s.err_cnt + CNT_ONE; // R9
        end

        // Sticky status: a new event beats a clear in the same cycle
        next_s.irq_stat = (s.irq_stat & ~clr) | ev;
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);

        // Register reads; data stand for exactly one cycle
        if (rd_stb) begin // R8
            case (addr)
                A_CTRL: begin
                    rd[CB_PASS] = s.pass;
                    rd[CB_FOVR] = s.fovr;
                end
                A_FLAG_OVR: begin
                    rd[FLAGS_W-1:0] = s.flag_ovr;
                end
                A_STD_OVR: begin
                    rd[STD_OVR_W-1:0] = s.std_ovr;
                end
                A_FLAGS: begin
                    rd[FLAGS_W-1:0] = s.held; // R7
                end
                A_ERR_CNT: begin
                    rd[CNT_W-1:0] = s.err_cnt; // R9
                end
                A_STD_STAT: begin
                    rd[STD_W-1:0] = eff_std;
                end
                A_INT_STAT: begin
                    rd[IRQ_W-1:0] = s.irq_stat;
                end
                A_INT_EN: begin
                    rd[IRQ_W-1:0] = s.irq_en;
                end
                default: begin
                    if (rsv_hit(addr)) begin
                        rd[VID_W-1:0] = s.rsv[rsv_idx(addr)]; // R11
                    end
                end
            endcase
        end
        next_s.rdata = rd; // R8

        // Indication pins, top pin is bit 2
        if (field_std_select) begin
            next_s.ind = field_number; // R2
        end else begin
            next_s.ind = {eff_std[SB_PAL], eff_std[SB_SAMP], eff_std[SB_LUM]}; // R1
        end

        // Flag pair selection from the held field flags
        case ({flag_select_msb, flag_select_lsb}) // R15
            2'b00: begin
                next_s.fl_hi = s.held[RG_FF+FB_ALREADY]; // R3
                next_s.fl_lo = s.held[RG_FF+FB_EDH]; // R3
            end
            2'b01: begin
                next_s.fl_hi = region_or(s.held, FB_UNKNOWN); // R4
                next_s.fl_lo = s.held[RG_AP+FB_EDH]; // R3
            end
            2'b10: begin
                next_s.fl_hi = s.held[RG_ANC+FB_ALREADY]; // R3
                next_s.fl_lo = s.held[RG_ANC+FB_EDH]; // R3
            end
            default: begin
                next_s.fl_hi = region_or(s.held, FB_FAULT_UP); // R4
                next_s.fl_lo = region_or(s.held, FB_FAULT_HERE); // R4
            end
        endcase

        // Flags handed to packet insertion: host values replace computed
        if (s.fovr) begin
            next_s.ins_flags = s.flag_ovr; // R7
        end else begin
            next_s.ins_flags = s.held; // R12
        end
        next_s.ins_en = ~s.pass; // R10
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.irq_en <= IRQ_EN_RST;
            s.ins_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Video delay
    // ------------------------------------------------------------

    // Same delay in every mode, so downstream timing never shifts
    edhso_delay u_delay ( // R14
        .mclk(mclk),
        .rst_b(rst_b),
        .din(din),
        .dout(dout)
    );

    // ------------------------------------------------------------
    // Outputs, each straight from a state flip-flop
    // ------------------------------------------------------------
    assign indication_bit2 = s.ind[2];
    assign indication_bit1 = s.ind[1];
    assign indication_bit0 = s.ind[0];
    assign flag_out_high = s.fl_hi; // R13
    assign flag_out_low = s.fl_lo; // R13
    assign insert_enable = s.ins_en;
    assign insert_flags = s.ins_flags;
    assign reserved_words = s.rsv;
    assign rdata = s.rdata;
    assign irq = s.irq;
endmodule : edhso_top
`default_nettype wire

// file: test/edhso_sva.sv
// Assertion checker bound to the EDH status and output select top
`timescale 1ns/100ps
`default_nettype none
module edhso_sva
    import edhso_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Pins and stream inputs
    input wire logic mode_receive,
    input wire logic field_std_select,
    input wire logic flag_select_lsb,
    input wire logic flag_select_msb,
    input wire logic [VID_W-1:0] din,
    input wire logic field_start,
    input wire logic [FIELD_W-1:0] field_number,
    input wire logic edh_packet_seen,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    // Outputs
    input wire logic [VID_W-1:0] dout,
    input wire logic indication_bit2,
    input wire logic indication_bit1,
    input wire logic indication_bit0,
    input wire logic flag_out_high,
    input wire logic flag_out_low,
    input wire logic insert_enable,
    input wire logic [FLAGS_W-1:0] insert_flags
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [2:0] up_cnt;
    logic pkt_seen;
    wire logic [1:0] fsel = {flag_select_msb, flag_select_lsb};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Cycles since reset, so the delay check never looks back into reset;
    // a packet in the boundary cycle also counts for the next field: no false alarm
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt <= 3'h0;
            pkt_seen <= 1'b0;
        end else begin
            up_cnt <= (up_cnt == 3'h4) ? up_cnt : up_cnt + 3'h1;
            pkt_seen <= (pkt_seen & ~field_start) | edh_packet_seen;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_video_delay: assert property (up_cnt == 3'h4 |-> dout == $past(din, 4))
        else $error("video output not four cycles behind input");
    a_field_pins: assert property (field_std_select |=>
        {indication_bit2, indication_bit1, indication_bit0} == $past(field_number))
        else $error("indication pins do not show field number");
    a_read_idle: assert property (!$past(rd_stb) |-> rdata == '0)
        else $error("read data outside the answer cycle");
    a_flag_hold: assert property ((!field_start && $stable(fsel))[*2] |=>
        $stable({flag_out_high, flag_out_low}))
        else $error("flag pins moved within a field");
    a_xmit_clear: assert property (field_start && !mode_receive |->
        ##2 !flag_out_high && !flag_out_low)
        else $error("transmit field left a flag set");
    a_unknown_missing: assert property (field_start && mode_receive && !edh_packet_seen &&
        !pkt_seen ##1 fsel == 2'h1 |=> flag_out_high)
        else $error("missing packet did not raise unknown status");
    a_pass_mode: assert property (wr_stb && addr == A_CTRL |->
        ##2 insert_enable == !$past(wdata[CB_PASS], 2))
        else $error("insert enable does not follow pass-through bit");
    a_insert_hold: assert property ($changed(insert_flags) |-> $past(field_start) ||
        $past(field_start, 2) || $past(wr_stb) || $past(wr_stb, 2))
        else $error("insert flags changed without cause");
    c_err_field: cover property (field_start && mode_receive ##2 flag_out_high);
    c_xmit_field: cover property (field_start && !mode_receive);
    c_pass_on: cover property ($fell(insert_enable));
endmodule : edhso_sva

bind edhso_top edhso_sva u_edhso_sva (
    .mclk(mclk), .rst_b(rst_b), .mode_receive(mode_receive),
    .field_std_select(field_std_select), .flag_select_lsb(flag_select_lsb),
    .flag_select_msb(flag_select_msb), .din(din), .field_start(field_start),
    .field_number(field_number), .edh_packet_seen(edh_packet_seen), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .dout(dout),
    .indication_bit2(indication_bit2), .indication_bit1(indication_bit1),
    .indication_bit0(indication_bit0), .flag_out_high(flag_out_high),
    .flag_out_low(flag_out_low), .insert_enable(insert_enable), .insert_flags(insert_flags)
);
`default_nettype wire

// file: test/edhso_vid_port.sv
// Partner model of the parallel video port: stream and field boundaries
`timescale 1ns/100ps
`default_nettype none
module edhso_vid_port
    import edhso_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Field request from the bench
    input wire logic go,
    input wire logic pkt,
    input wire logic [FLAGS_W-1:0] flags,
    // Port toward the block
    output logic [VID_W-1:0] din,
    output logic field_start,
    output logic [FIELD_W-1:0] field_number,
    output logic [FLAGS_W-1:0] computed_flags,
    output logic edh_packet_seen
);
    logic arm;

    // Packet pulse, then boundary one cycle later; flags are only valid at the
    // boundary, so they toggle elsewhere to catch a capture at the wrong time
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            din <= '0;
            field_start <= 1'b0;
            field_number <= '0;
            computed_flags <= '0;
            edh_packet_seen <= 1'b0;
            arm <= 1'b0;
        end else begin
            din <= din + 10'h3B;
            edh_packet_seen <= go & pkt;
            arm <= go;
            field_start <= arm;
            computed_flags <= arm ? flags : ~computed_flags;
            field_number <= arm ? field_number + 3'h1 : field_number;
        end
    end
endmodule : edhso_vid_port
`default_nettype wire

// file: test/edhso_top_tb.sv
// Self-checking bench for the EDH status and output select block
`timescale 1ns/100ps
`default_nettype none
module edhso_top_tb import edhso_pkg::*;;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic mode = 1'b1;
    logic fsts = 1'b0;
    logic [1:0] fsel = 2'h0;
    logic [STD_W-1:0] std = '0;
    logic go = 1'b0;
    logic pkt = 1'b0;
    logic [FLAGS_W-1:0] flags = '0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [VID_W-1:0] din, dout, v;
    logic fs, seen, i2, i1, i0, fl_hi, fl_lo, ins_en, irq;
    logic [FIELD_W-1:0] fnum;
    logic [FIELD_W-1:0] exp_fn = '0;
    logic [FLAGS_W-1:0] cflags, ins_flags, held;
    logic [RSV_N*VID_W-1:0] rsv;
    logic [DATA_W-1:0] rdata;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_err = 0;

    // Clock of 100 ns period
    always #50 mclk = ~mclk;

    edhso_vid_port u_edhso_vid_port (
        .mclk(mclk), .rst_b(rst_b), .go(go), .pkt(pkt), .flags(flags), .din(din),
        .field_start(fs), .field_number(fnum), .computed_flags(cflags), .edh_packet_seen(seen)
    );
    edhso_top u_edhso_top (
        .mclk(mclk), .rst_b(rst_b), .mode_receive(mode), .field_std_select(fsts),
        .flag_select_lsb(fsel[0]), .flag_select_msb(fsel[1]), .din(din), .dout(dout),
        .field_start(fs), .field_number(fnum), .std_detected(std), .computed_flags(cflags),
        .edh_packet_seen(seen), .indication_bit2(i2), .indication_bit1(i1),
        .indication_bit0(i0), .flag_out_high(fl_hi), .flag_out_low(fl_lo),
        .insert_enable(ins_en), .insert_flags(ins_flags), .reserved_words(rsv), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq)
    );

    task automatic check(input logic [DATA_W-1:0] seen_v, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen_v !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen_v, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] m);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        check(rdata & m, e);
    endtask : rd_chk

    // Flag pair expected for each select code
    function automatic logic [1:0] exp_pins(input logic [1:0] c, input logic [FLAGS_W-1:0] h);
        case (c)
            2'h0: exp_pins = {h[RG_FF+FB_ALREADY], h[RG_FF+FB_EDH]};
            2'h1: exp_pins = {|(h & UNKNOWN_ALL_MASK), h[RG_AP+FB_EDH]};
            2'h2: exp_pins = {h[RG_ANC+FB_ALREADY], h[RG_ANC+FB_EDH]};
            default: exp_pins = {h[FB_FAULT_UP] | h[RG_FF+FB_FAULT_UP] | h[RG_ANC+FB_FAULT_UP],
                h[FB_FAULT_HERE] | h[RG_FF+FB_FAULT_HERE] | h[RG_ANC+FB_FAULT_HERE]};
        endcase
    endfunction : exp_pins

    // One field, then every flag pair and the held flags register
    task automatic field(input logic [FLAGS_W-1:0] f, input logic p);
        @(posedge mclk);
        flags <= f;
        pkt <= p;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        exp_fn = exp_fn + 3'h1;
        held = mode ? (f | (p ? '0 : UNKNOWN_ALL_MASK)) : '0;
        n_err += int'(mode && (f & ERR_MASK) != '0);
        tick(4);
        check({i2, i1, i0}, exp_fn);
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            fsel <= c[1:0];
            tick(2);
            check({fl_hi, fl_lo}, exp_pins(c[1:0], held));
        end
        rd_chk(A_FLAGS, 32'(held), '1);
    endtask : field

    // Watchdog: a hung sequence still ends in the verdict
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        rd_chk(A_INT_EN, 32'h7, '1);
        rd_chk(8'h30, '0, '1);
        for (int s = 0; s < 8; s++) begin
            @(posedge mclk);
            std <= s[2:0];
            tick(2);
            check({i2, i1, i0}, s[2:0]);
            rd_chk(A_STD_STAT, 32'(s), '1);
        end
        wr(A_STD_OVR, 32'hD);
        rd_chk(A_STD_STAT, 32'h5, '1);
        wr(A_STD_OVR, 32'h0);
        @(posedge mclk);
        fsts <= 1'b1;
        for (int b = 0; b < FLAGS_W; b++) begin
            field(FLAGS_W'(1) << b, 1'b1);
        end
        // Unknown-status pair on the pins at the boundary, so the checker sees it
        @(posedge mclk);
        fsel <= 2'h1;
        field('0, 1'b0);
        rd_chk(A_ERR_CNT, 32'(n_err), '1);
        wr(A_ERR_CNT, '0);
        rd_chk(A_ERR_CNT, '0, '1);
        field(15'h0021, 1'b1);
        wr(A_FLAG_OVR, 32'h2A5A);
        wr(A_CTRL, 32'h2);
        tick(2);
        check(ins_flags, 15'h2A5A);
        wr(A_CTRL, 32'h1);
        tick(2);
        check(ins_flags, held);
        check(ins_en, 1'b0);
        rd_chk(A_CTRL, 32'h1, '1);
        wr(A_CTRL, 32'h0);
        @(posedge mclk);
        mode <= 1'b0;
        field(15'h739C, 1'b1);
        @(posedge mclk);
        mode <= 1'b1;
        // Errored-field interrupt: raise, mask, clear
        wr(A_INT_CLR, 32'h7);
        wr(A_INT_EN, 32'h1);
        tick(2);
        check(irq, 1'b0);
        field(15'h0001, 1'b1);
        check(irq, 1'b1);
        rd_chk(A_INT_STAT, 32'h1, 32'h1);
        wr(A_INT_EN, 32'h0);
        tick(2);
        check(irq, 1'b0);
        wr(A_INT_CLR, 32'h1);
        rd_chk(A_INT_STAT, 32'h0, 32'h1);
        // Reserved words: upper write bits must be dropped
        for (int i = 0; i < RSV_N; i++) begin
            v = 10'h3C5 ^ 10'(i * 75);
            wr(A_RSV_BASE + 8'(4 * i), 32'hFFFFFC00 | 32'(v));
        end
        for (int i = 0; i < RSV_N; i++) begin
            v = 10'h3C5 ^ 10'(i * 75);
            rd_chk(A_RSV_BASE + 8'(4 * i), 32'(v), '1);
            check(rsv[i*VID_W +: VID_W], v);
        end
        end_sim();
    end
endmodule : edhso_top_tb
`default_nettype wire
